// *** rtl/adcsq_pkg.sv ***
// Summary of operation
// R1: Trigger 111 with auto-sample keeps looping acquisition then conversion unaided.
// R2: Counter trigger ends acquisition after sample-time field (bits 12:8) conversion clocks.
// R3: Control register two = 0x0004 gives an interrupt every two samples.
// R4: Trigger 010 lets a timer-three compare end sampling and start conversion.
// R5: Alternate-input bit clear means every sample uses multiplexer A selections; from idle the code still uses B if B was next at the last conversion.
// R6: Multiplexer A positive input comes from bits 19:16; 0000 is input zero.
// R7: Negative-select bit 23 at 0 connects the negative reference.
// R8: Each result goes to the next buffer word, from word 0, one per conversion.
// R9: After the sample count, raise the interrupt and refill from the first word.
// R10: Buffer-split bit at 0 means one single buffer of sixteen words.
// R11: Software makes acquisition longer than the converter's minimum requirement.
// R12: Software programs sample time to at least one conversion clock.
// R13: Auto modes set done at sequence end and clear it at next acquisition; the code clears it one acquisition later.
// R14: Conversion count and write pointer return to zero with each interrupt; with buffer split set the pointer alternates between word 8 and word 0.
// R15: Clearing auto-sample stops new acquisitions after the current conversion.
package adcsq_pkg;
  localparam logic [7:0] CTRL1_OFS = 8'h00;
  localparam logic [7:0] CTRL2_OFS = 8'h04;
  localparam logic [7:0] CTRL3_OFS = 8'h08;
  localparam logic [7:0] INSEL_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;
  localparam logic [7:0] BUF_OFS = 8'h40;
  localparam int BUF_WORDS = 16;
  localparam int ON_BIT = 15;
  localparam int TRIG_LSB = 5;
  localparam int AUTO_BIT = 2;
  localparam int SAMP_BIT = 1;
  localparam int DONE_BIT = 0;
  localparam int SAMPLES_PER_INTERRUPT_LSB = 2;
  localparam int SPLIT_BIT = 1;
  localparam int ALT_BIT = 0;
  localparam int STIME_LSB = 8;
  localparam int POSA_LSB = 16;
  localparam int NEGA_BIT = 23;
  localparam int POSB_LSB = 24;
  localparam int NEGB_BIT = 31;
  localparam int ST_SEQ = 0;
  localparam int ST_CONV = 1;
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_CLOCK = 3'h7;
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam logic [5:0] CTRL2_RST = 6'h00;
  localparam logic [12:0] CTRL3_RST = 13'h0000;
  localparam logic [31:0] INSEL_RST = 32'h0000_0000;
  localparam logic [7:0] TAD_DIV_RST = 8'h00;
  typedef enum logic [1:0] {SQ_IDLE, SQ_ACQ, SQ_CONV} adcsq_state_e;
endpackage

// *** rtl/adcsq_tad_if.sv ***
`timescale 1ns/1ps
interface adcsq_tad_if;
  logic [7:0] div;
  logic run;
  logic tick;
  modport seq (output div, output run, input tick);
  modport gen (input div, input run, output tick);
endinterface

// *** rtl/adcsq_tad_gen.sv ***
`timescale 1ns/1ps
module adcsq_tad_gen (
  input wire logic clk,
  input wire logic nrst,
  adcsq_tad_if.gen tad
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // One conversion clock period is div+1 system clocks
  // Tick marks the last clock of each period, so the first period has full length
  always_comb begin
    cnt_nxt = 8'h00;
    if (tad.run && cnt_r < tad.div) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tad.tick = tad.run && cnt_r >= tad.div;
endmodule

// *** rtl/adcsq_sequencer.sv ***
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module adcsq_sequencer
  import adcsq_pkg::*;
#(
  parameter int DATA_W = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timerEvent,
  input wire logic convDone,
  input wire logic [DATA_W-1:0] convData,
  output logic sampleHold,
  output logic convStart,
  output logic [3:0] posSelect,
  output logic negSelect,
  output logic irq
);
  adcsq_tad_if tadIf ();

  adcsq_tad_gen u_tad (
    .clk(clk),
    .nrst(nrst),
    .tad(tadIf.gen)
  );

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= MASK_OFS || a >= BUF_OFS);
  endfunction

  // Converter pins pass two flip-flops
  logic doneMeta_r;
  logic doneSync_r;
  logic donePrev_r;
  logic [DATA_W-1:0] dataMeta_r;
  logic [DATA_W-1:0] dataSync_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      doneMeta_r <= 1'b0;
      doneSync_r <= 1'b0;
      donePrev_r <= 1'b0;
      dataMeta_r <= '0;
      dataSync_r <= '0;
    end else begin
      doneMeta_r <= convDone;
      doneSync_r <= doneMeta_r;
      donePrev_r <= doneSync_r;
      dataMeta_r <= convData;
      dataSync_r <= dataMeta_r;
    end
  end

  logic doneEdge;
  assign doneEdge = doneSync_r && !donePrev_r;

  // APB slave: one wait state, read data and error set up with pready
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [31:0] rdVal;
  logic wrAcc;

  logic [15:0] ctrl1_r;
  logic [15:0] ctrl1_nxt;
  logic [5:0] ctrl2_r;
  logic [5:0] ctrl2_nxt;
  logic [12:0] ctrl3_r;
  logic [12:0] ctrl3_nxt;
  logic [31:0] insel_r;
  logic [31:0] insel_nxt;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  logic done_r;
  logic done_nxt;
  logic [DATA_W-1:0] buf_r [BUF_WORDS];
  logic [DATA_W-1:0] buf_nxt [BUF_WORDS];
  adcsq_state_e state_r;
  adcsq_state_e state_nxt;
  logic [4:0] tadCnt_r;
  logic [4:0] tadCnt_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] ptr_r;
  logic [3:0] ptr_nxt;
  logic half_r;
  logic half_nxt;
  logic altB_r;
  logic altB_nxt;
  logic hold_r;
  logic hold_nxt;
  logic start_r;
  logic start_nxt;
  logic [3:0] pos_r;
  logic [3:0] pos_nxt;
  logic neg_r;
  logic neg_nxt;
  logic irq_r;

  always_comb begin
    rdVal = 32'h0000_0000;
    if (paddr >= BUF_OFS) begin
      rdVal[DATA_W-1:0] = buf_r[paddr[5:2]];
    end else begin
      unique case (paddr)
        CTRL1_OFS: rdVal = {16'h0000, ctrl1_r[15:1], done_r};
        CTRL2_OFS: rdVal = {26'h0, ctrl2_r};
        CTRL3_OFS: rdVal = {19'h0, ctrl3_r};
        INSEL_OFS: rdVal = insel_r;
        STAT_OFS: rdVal = {30'h0, stat_r};
        MASK_OFS: rdVal = {30'h0, mask_r};
        default: rdVal = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (psel && penable && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !isMapped(paddr);
      prdata_nxt = isMapped(paddr) ? rdVal : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign wrAcc = psel && penable && pready_r && pwrite && !pslverr_r;

  logic isOn;
  logic autoOn;
  logic [2:0] trig;
  logic [3:0] samples_per_interrupt;
  logic [4:0] stime;
  logic swSamp;
  logic acqEnd;
  logic seqEnd;
  assign isOn = ctrl1_r[ON_BIT];
  assign autoOn = ctrl1_r[AUTO_BIT];
  assign trig = ctrl1_r[TRIG_LSB+:3];
  assign samples_per_interrupt = ctrl2_r[SAMPLES_PER_INTERRUPT_LSB+:4];
  assign stime = ctrl3_r[STIME_LSB+:5];
  assign swSamp = wrAcc && paddr == CTRL1_OFS && pwdata[SAMP_BIT];
  assign seqEnd = state_r == SQ_CONV && doneEdge && cnt_r == samples_per_interrupt;

  always_comb begin
    acqEnd = 1'b0;
    unique case (trig)
      TRIG_CLOCK: acqEnd = tadIf.tick && tadCnt_r + 5'h01 >= stime; // see R2
      TRIG_TIMER: acqEnd = timerEvent; // see R4
      TRIG_MANUAL: acqEnd = swSamp;
      default: acqEnd = swSamp;
    endcase
  end

  always_comb begin
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    ctrl3_nxt = ctrl3_r;
    insel_nxt = insel_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    done_nxt = done_r;
    buf_nxt = buf_r;
    state_nxt = state_r;
    tadCnt_nxt = tadCnt_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    half_nxt = half_r;
    altB_nxt = altB_r;
    hold_nxt = hold_r;
    start_nxt = 1'b0;
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    if (wrAcc) begin
      unique case (paddr)
        CTRL1_OFS: begin
          ctrl1_nxt = pwdata[15:0];
          done_nxt = done_r && pwdata[DONE_BIT];
        end
        CTRL2_OFS: ctrl2_nxt = pwdata[5:0];
        CTRL3_OFS: ctrl3_nxt = pwdata[12:0];
        INSEL_OFS: insel_nxt = pwdata;
        STAT_OFS: stat_nxt = stat_r & ~pwdata[1:0];
        MASK_OFS: mask_nxt = pwdata[1:0];
        default: ;
      endcase
    end
    unique case (state_r)
      SQ_IDLE: begin
        if (isOn && (autoOn || swSamp)) begin
          state_nxt = SQ_ACQ;
        end
      end
      SQ_ACQ: begin
        if (tadIf.tick) begin
          tadCnt_nxt = tadCnt_r + 5'h01; // see R2
        end
        if (acqEnd) begin
          state_nxt = SQ_CONV;
          hold_nxt = 1'b0;
          start_nxt = 1'b1;
        end
      end
      SQ_CONV: begin
        if (doneEdge) begin
          buf_nxt[ptr_r] = dataSync_r; // see R8
          stat_nxt[ST_CONV] = 1'b1;
          altB_nxt = ctrl2_r[ALT_BIT] && !altB_r; // see R5
          if (seqEnd) begin
            stat_nxt[ST_SEQ] = 1'b1; // see R3, R9
            done_nxt = 1'b1; // see R13
            cnt_nxt = 4'h0; // see R14
            half_nxt = ctrl2_r[SPLIT_BIT] && !half_r;
            ptr_nxt = {half_nxt, 3'h0}; // see R9, R10, R14
          end else begin
            cnt_nxt = cnt_r + 4'h1;
            ptr_nxt = ptr_r + 4'h1; // see R8, R10
          end
          // Auto-sample cleared: park after this conversion
          state_nxt = (autoOn && isOn) ? SQ_ACQ : SQ_IDLE; // see R1, R15
        end
      end
    endcase
    if (state_r != SQ_ACQ && state_nxt == SQ_ACQ) begin
      tadCnt_nxt = 5'h00;
      hold_nxt = 1'b1;
      if (autoOn && !seqEnd) begin
        done_nxt = 1'b0; // see R13
      end
      if (altB_nxt) begin
        pos_nxt = insel_r[POSB_LSB+:4];
        neg_nxt = insel_r[NEGB_BIT];
      end else begin
        pos_nxt = insel_r[POSA_LSB+:4]; // see R5, R6
        neg_nxt = insel_r[NEGA_BIT]; // see R7
      end
    end
    if (!isOn) begin
      state_nxt = SQ_IDLE;
      hold_nxt = 1'b0;
      start_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
      ctrl3_r <= CTRL3_RST;
      insel_r <= INSEL_RST;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      done_r <= 1'b0;
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_r[i] <= '0;
      end
      state_r <= SQ_IDLE;
      tadCnt_r <= 5'h00;
      cnt_r <= 4'h0;
      ptr_r <= 4'h0;
      half_r <= 1'b0;
      altB_r <= 1'b0;
      hold_r <= 1'b0;
      start_r <= 1'b0;
      pos_r <= 4'h0;
      neg_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      ctrl3_r <= ctrl3_nxt;
      insel_r <= insel_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      done_r <= done_nxt;
      buf_r <= buf_nxt;
      state_r <= state_nxt;
      tadCnt_r <= tadCnt_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      half_r <= half_nxt;
      altB_r <= altB_nxt;
      hold_r <= hold_nxt;
      start_r <= start_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  assign tadIf.div = ctrl3_r[7:0];
  assign tadIf.run = state_r == SQ_ACQ;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sampleHold = hold_r;
  assign convStart = start_r;
  assign posSelect = pos_r;
  assign negSelect = neg_r;
  assign irq = irq_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence convFinish;
    state_r == SQ_CONV && doneEdge && isOn;
  endsequence

  sequence acqRestart;
    state_r == SQ_ACQ ##0 sampleHold;
  endsequence

  clock_acq_len_a: assert property ( // see R2
    state_r == SQ_ACQ && trig == TRIG_CLOCK && isOn && stime != 5'h00
      && state_nxt == SQ_CONV |-> tadCnt_r + 5'h01 == stime)
    else $error("acquisition length differs from sample time");

  timer_trig_a: assert property ( // see R4
    state_r == SQ_ACQ && trig == TRIG_TIMER && timerEvent && isOn
      |=> state_r == SQ_CONV ##0 convStart)
    else $error("timer compare did not start conversion");

  auto_loop_a: assert property ( // see R1
    convFinish ##0 autoOn |=> acqRestart)
    else $error("auto sampling did not restart acquisition");

  auto_stop_a: assert property ( // see R15
    convFinish ##0 !autoOn |=> state_r == SQ_IDLE ##1 !sampleHold)
    else $error("acquisition started with auto sampling off");

  seq_irq_a: assert property ( // see R3, R9, R14
    seqEnd && isOn |=> stat_r[ST_SEQ] && cnt_r == 4'h0 && done_r
      && (ctrl2_r[SPLIT_BIT] || ptr_r == 4'h0))
    else $error("sequence end did not flag and rewind");

  ptr_step_a: assert property ( // see R8, R10
    state_r == SQ_CONV && doneEdge && !seqEnd && isOn
      |=> ptr_r == $past(ptr_r) + 4'h1)
    else $error("buffer pointer did not advance by one");

  muxa_sel_a: assert property ( // see R5, R6, R7
    $rose(sampleHold) && !ctrl2_r[ALT_BIT] && !$past(altB_r)
      |-> posSelect == $past(insel_r[POSA_LSB+:4])
      && negSelect == $past(insel_r[NEGA_BIT]))
    else $error("multiplexer A selection not applied");

  done_clear_a: assert property ( // see R13
    $rose(sampleHold) && $past(autoOn) && !$past(seqEnd) |-> !done_r)
    else $error("done flag not cleared at acquisition start");

  irq_level_a: assert property (
    irq == $past(|(stat_nxt & mask_nxt)))
    else $error("interrupt level does not follow status and mask");
endmodule

// *** test/adcsq_conv_model.sv ***
`timescale 1ns/1ps
module adcsq_conv_model (
  input wire logic clk,
  input wire logic convStart,
  input wire logic [3:0] posSelect,
  input wire logic [7:0] lat,
  output logic convDone,
  output logic [9:0] convData
);
  int cnt;
  int hold;
  logic [5:0] seq;
  logic [3:0] chan;
  initial begin
    cnt = 0;
    hold = 0;
    seq = 6'h00;
    chan = 4'h0;
    convDone = 1'b0;
    convData = 10'h3ff;
  end
  // Result carries a running count and the selected input
  always @(posedge clk) begin
    if (convStart) begin
      cnt <= int'(lat) + 1;
      chan <= posSelect;
    end else if (cnt == 1) begin
      convDone <= 1'b1;
      convData <= {seq, chan};
      seq <= seq + 6'h01;
      hold <= 6;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
    // Released data no longer shows the last value
    if (hold == 1) begin
      convDone <= 1'b0;
      convData <= ~convData;
    end
    if (hold > 0) begin
      hold <= hold - 1;
    end
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb
  import adcsq_pkg::*;
;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } adcsq_row_s;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, timerEvent;
  logic convDone, sampleHold, convStart, negSelect, irq, chkSel;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata, r;
  logic [9:0] convData;
  logic [3:0] posSelect;
  logic e;
  int mismatches = 0, n_checks = 0, nStart = 0, acq = 0, lastAcq = 0, n0;
  adcsq_row_s rows[12] = '{
    '{1'b0, CTRL2_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b1, CTRL3_OFS, 32'h0000_0300, 32'h0, 1'b0},
    '{1'b0, CTRL3_OFS, 32'h0, 32'h0000_0300, 1'b0},
    '{1'b1, INSEL_OFS, 32'h8503_0000, 32'h0, 1'b0},
    '{1'b0, INSEL_OFS, 32'h0, 32'h8503_0000, 1'b0},
    '{1'b1, CTRL2_OFS, 32'h0000_0004, 32'h0, 1'b0},
    '{1'b0, CTRL2_OFS, 32'h0, 32'h0000_0004, 1'b0},
    '{1'b1, BUF_OFS, 32'h0000_0001, 32'h0, 1'b0},
    '{1'b0, BUF_OFS, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h30, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h05, 32'h0000_0001, 32'h0, 1'b1},
    '{1'b1, MASK_OFS, 32'h0000_0001, 32'h0, 1'b0}};

  adcsq_sequencer #(.DATA_W(10)) i_adcsq_sequencer (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerEvent(timerEvent), .convDone(convDone),
    .convData(convData), .sampleHold(sampleHold), .convStart(convStart),
    .posSelect(posSelect), .negSelect(negSelect), .irq(irq));
  adcsq_conv_model i_adcsq_conv_model (.clk(clk), .convStart(convStart),
    .posSelect(posSelect), .lat(lat), .convDone(convDone), .convData(convData));

  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, s, x);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(irq), 32'h1);
  endtask

  // Acquisition length and input selection at each conversion start
  always @(posedge clk) begin
    if (convStart === 1'b1) begin
      nStart++;
      if (chkSel) begin
        chk(32'(posSelect), 32'h3);
        chk(32'(negSelect), 32'h0);
      end
    end
    if (sampleHold === 1'b1) acq++;
    else if (acq != 0) begin
      lastAcq = acq;
      acq = 0;
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    $display("mismatch at %0t: timeout", $time);
    end_sim;
  end

  initial begin
    {clk, psel, penable, pwrite, timerEvent, chkSel} = 6'h00;
    {paddr, pwdata} = 40'h0;
    lat = 8'd20;
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(r, rows[i].x);
      chk(32'(e), 32'(rows[i].e));
    end
    $display("test registers done");
    chkSel = 1'b1;
    apb(1'b1, CTRL1_OFS, 32'h0000_80e4);
    for (int k = 0; k < 2; k++) begin
      wait_irq;
      for (int i = 0; i < 2; i++) begin
        apb(1'b0, BUF_OFS + 8'(4 * i), 32'h0);
        chk(r, {22'h0, 6'(2 * k + i), 4'h3});
      end
      apb(1'b0, BUF_OFS + 8'h20, 32'h0);
      chk(r, 32'h0);
      chk(32'(lastAcq), 32'h3);
      apb(1'b1, STAT_OFS, 32'h1);
      @(posedge clk);
      chk(32'(irq), 32'h0);
    end
    apb(1'b1, MASK_OFS, 32'h0);
    repeat (150) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(r & 32'h1, 32'h1);
    apb(1'b1, MASK_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    $display("test free running done");
    lat <= 8'd1;
    apb(1'b1, CTRL1_OFS, 32'h0000_80e0);
    n0 = nStart;
    repeat (200) @(posedge clk);
    chk(32'(nStart <= n0 + 1), 32'h1);
    chk(32'(sampleHold), 32'h0);
    $display("test stop done");
    apb(1'b1, CTRL1_OFS, 32'h0000_8044);
    n0 = nStart;
    repeat (30) @(posedge clk);
    chk(32'(sampleHold), 32'h1);
    chk(32'(nStart), 32'(n0));
    timerEvent <= 1'b1;
    @(posedge clk);
    timerEvent <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(nStart), 32'(n0 + 1));
    $display("test timer done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, CTRL1_OFS, 32'h0);
    chk(r, 32'h0);
    chk(32'({irq, sampleHold}), 32'h0);
    $display("test reset done");
    end_sim;
  end
endmodule
